// >>> bench/fid_link_properties.sv
// Checker for the host-device link: wire ownership, framing, read turnaround.
// Assumes it sits beside the link, on the system clock and reset.
`timescale 1ns/1ns
module fid_link_properties (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       cs_n,
    input wire logic       ck,
    input wire logic [7:0] h_dq_o,
    input wire logic       h_dq_oe_n,
    input wire logic [7:0] d_dq_o,
    input wire logic       d_dq_oe_n,
    input wire logic [7:0] dq
);
    logic       ck_reg,   ck_next;
    logic [3:0] edge_reg, edge_next;
    logic [2:0] type_reg, type_next;

    // Count link edges per frame; the count survives one cycle past the frame end
    always_comb begin
        ck_next   = ck;
        edge_next = cs_n ? 4'h0 : edge_reg + 4'(ck != ck_reg);
        type_next = (!cs_n && ck != ck_reg && edge_reg == 4'h0) ? dq[7:5] : type_reg;
    end

    // Registers only
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ck_reg   <= 1'b0;
            edge_reg <= 4'h0;
            type_reg <= 3'h0;
        end else begin
            ck_reg   <= ck_next;
            edge_reg <= edge_next;
            type_reg <= type_next;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Device answer window is two link slots wide
    sequence dev_answers; ##[0:8] !d_dq_oe_n; endsequence
    sequence frame_closed; $rose(cs_n); endsequence

    one_driver_a: assert property (h_dq_oe_n || d_dq_oe_n)
        else $error("both ends drive the data wire");
    // The device sees select through two flops, so it lets go three cycles late
    idle_quiet_a: assert property (cs_n && $past(cs_n) && $past(cs_n, 2)
        && $past(cs_n, 3) |-> d_dq_oe_n) else $error("device drives while deselected");
    ck_still_a: assert property (cs_n && $past(cs_n) |-> $stable(ck))
        else $error("link clock moves between frames");
    write_silent_a: assert property (!cs_n && edge_reg != 4'h0
        && type_reg == fid_pkg::CA_WR_MEM |-> d_dq_oe_n) else $error("device drives in a write");
    rd_release_a: assert property (!cs_n && type_reg == fid_pkg::CA_RD_MEM
        && edge_reg >= 4'h7 |-> h_dq_oe_n) else $error("host keeps the wire in a read");
    rd_answer_a: assert property (!cs_n && type_reg == fid_pkg::CA_RD_MEM
        && edge_reg == 4'h7 |-> dev_answers) else $error("device gives no read data");
    frame_len_a: assert property (frame_closed |-> edge_reg ==
        (type_reg == fid_pkg::CA_RD_MEM ? fid_pkg::RD_EDGES : fid_pkg::WR_EDGES))
        else $error("frame edge count wrong");
    frame_gap_a: assert property (frame_closed |-> cs_n[*4])
        else $error("frames too close together");
endmodule

// >>> bench/flash_integrity_command_decoder_tb_top.sv
// Testbench joining host and device over the link; checks each integrity command.
// Assumes the package, the link and both ends are compiled first.
`timescale 1ns/1ns
module flash_integrity_command_decoder_tb_top;
    logic        i_sys_clk, i_rst_n, i_req, i_req_read, o_ready, o_rdata_valid;
    logic        o_mem_rd, o_ecc_clear, o_calc_suspended, o_calc_resume, ecc_seen, res_seen;
    logic        mrd_seen;
    logic [44:0] i_req_addr, o_mem_addr, sa;
    logic [15:0] i_req_wdata, o_rdata, rd_val;
    logic [31:0] i_icrc_value = 32'h1234_abcd;
    logic [31:0] i_dic_result = 32'h5a6b_7c8d;
    logic [15:0] i_mem_data   = 16'hc3a5;
    logic [1:0]  o_mode;
    logic [9:0]  o_start_sector, o_end_sector;
    int          fails = 0, cmp_count = 0;

    fid_link_if link ();
    fid_host fid_host_i (.i_sys_clk, .i_rst_n, .i_req, .i_req_read, .i_req_addr,
        .i_req_wdata, .o_ready, .o_rdata, .o_rdata_valid, .link(link.host));
    fid_device fid_device_i (.i_sys_clk, .i_rst_n, .i_icrc_value, .i_dic_result,
        .i_mem_data, .o_mem_addr, .o_mem_rd, .o_mode, .o_ecc_clear, .o_calc_suspended,
        .o_calc_resume, .o_start_sector, .o_end_sector, .link(link.dev));
    fid_link_properties fid_link_properties_i (.i_sys_clk, .i_rst_n, .cs_n(link.cs_n),
        .ck(link.ck), .h_dq_o(link.h_dq_o), .h_dq_oe_n(link.h_dq_oe_n),
        .d_dq_o(link.d_dq_o), .d_dq_oe_n(link.d_dq_oe_n), .dq(link.dq));

    // Clock; pulse outputs last one cycle, so they are caught in sticky flags
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        if (o_ecc_clear === 1'b1) ecc_seen <= 1'b1;
        if (o_calc_resume === 1'b1) res_seen <= 1'b1;
        if (o_mem_rd === 1'b1) mrd_seen <= 1'b1;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One frame; waits on settled outputs at the falling edge, then lets the command land
    task automatic xfer(input logic rd, input logic [44:0] a, input logic [15:0] d);
        int n;
        rd_val = 16'hxxxx;
        @(posedge i_sys_clk);
        i_req <= 1'b1;
        i_req_read <= rd;
        i_req_addr <= a;
        i_req_wdata <= d;
        @(posedge i_sys_clk);
        i_req <= 1'b0;
        for (n = 0; n < 100; n++) begin
            @(negedge i_sys_clk);
            if (o_rdata_valid === 1'b1) rd_val = o_rdata;
            if (o_ready === 1'b1) break;
        end
        if (n == 100) begin
            fails++;
            give_verdict();
        end
        repeat (3) @(negedge i_sys_clk);
    endtask
    task automatic wr(input logic [7:0] c, input logic [44:0] a);
        xfer(1'b0, a, {8'h00, c});
    endtask
    task automatic unlock(input logic [7:0] c, input logic [44:0] hi, input logic [11:0] a2);
        wr(fid_pkg::UNL_DATA_A, {hi[44:12], fid_pkg::UNL_ADDR_A});
        wr(fid_pkg::UNL_DATA_B, {hi[44:12], a2});
        wr(c, {hi[44:12], fid_pkg::UNL_ADDR_A});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_icrc();
        ecc_seen = 1'b0;
        wr(fid_pkg::CMD_ECC_CLR, 45'h1f_0000_0123);
        chk(32'(ecc_seen), 32'h1);
        unlock(fid_pkg::CMD_ICRC, 45'h0a5a_0000_0000, fid_pkg::UNL_ADDR_B);
        chk(32'(o_mode), 32'(fid_pkg::FID_MODE_ICRC));
        unlock(fid_pkg::CMD_DICRC, 45'h0, 12'h2ab);
        chk(32'(o_mode), 32'(fid_pkg::FID_MODE_ICRC));
        xfer(1'b1, 45'h0123_4564, 16'h0000);
        chk(32'(rd_val), 32'(i_icrc_value[15:0]));
        xfer(1'b1, 45'h1ff0_0001, 16'h0000);
        chk(32'(rd_val), 32'(i_icrc_value[31:16]));
        wr(fid_pkg::CMD_EXIT, 45'h0000_0777);
        chk(32'(o_mode), 32'(fid_pkg::FID_MODE_NORMAL));
    endtask
    task automatic t_dic();
        unlock(fid_pkg::CMD_DICRC, 45'h0, fid_pkg::UNL_ADDR_B);
        chk(32'(o_mode), 32'(fid_pkg::FID_MODE_DICRC));
        sa = 45'h0000_06be_0000;
        wr(fid_pkg::CMD_LD_STA, sa);
        chk(32'(o_start_sector), 32'(sa[26:17]));
        sa = 45'h0000_0042_0abc;
        wr(fid_pkg::CMD_LD_END, sa);
        chk(32'(o_end_sector), 32'(sa[26:17]));
        wr(fid_pkg::CMD_SUSP, 45'h0);
        chk(32'(o_calc_suspended), 32'h1);
        mrd_seen = 1'b0;
        xfer(1'b1, 45'h1234_5676, 16'h0000);
        chk(32'(rd_val), 32'(i_mem_data));
        chk(32'(mrd_seen), 32'h1);
        chk(o_mem_addr[31:0], 32'h1234_5676);
        res_seen = 1'b0;
        wr(fid_pkg::CMD_RESUME, 45'h0);
        chk({30'h0, res_seen, o_calc_suspended}, 32'h2);
        wr(fid_pkg::CMD_RESULT, 45'h0);
        xfer(1'b1, 45'h0000_1000, 16'h0000);
        chk(32'(rd_val), 32'(i_dic_result[15:0]));
        wr(fid_pkg::CMD_RESULT, 45'h0);
        xfer(1'b1, 45'h0000_1001, 16'h0000);
        chk(32'(rd_val), 32'(i_dic_result[31:16]));
        wr(fid_pkg::CMD_EXIT, 45'h0);
        unlock(fid_pkg::CMD_BOOT, 45'h1fff_0000_0000, fid_pkg::UNL_ADDR_B);
        chk(32'(o_mode), 32'(fid_pkg::FID_MODE_BOOT));
        wr(fid_pkg::CMD_EXIT, 45'h0);
        chk(32'(o_mode), 32'(fid_pkg::FID_MODE_NORMAL));
    endtask

    // Reset for two cycles, then the scenarios, then the verdict
    initial begin
        i_rst_n = 1'b0;
        i_req = 1'b0;
        i_req_read = 1'b0;
        i_req_addr = 45'h0;
        i_req_wdata = 16'h0000;
        ecc_seen = 1'b0;
        res_seen = 1'b0;
        mrd_seen = 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_icrc();
        t_dic();
        give_verdict();
    end
endmodule

// >>> hdl/fid_device.sv
// Device end: decodes integrity and overlay commands from link frames.
// Assumes memory data is valid two clocks after o_mem_rd; CRC inputs are stable.
`timescale 1ns/1ns
module fid_device (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic [31:0] i_icrc_value,
    input  wire logic [31:0] i_dic_result,
    input  wire logic [15:0] i_mem_data,
    output logic [44:0]      o_mem_addr,
    output logic             o_mem_rd,
    output logic [1:0]       o_mode,
    output logic             o_ecc_clear,
    output logic             o_calc_suspended,
    output logic             o_calc_resume,
    output logic [9:0]       o_start_sector,
    output logic [9:0]       o_end_sector,
    fid_link_if.dev          link
);

    typedef enum logic [1:0] {UNL_IDLE, UNL_ONE, UNL_TWO} fid_unl_t;

    // Pick low or high half of a 32-bit value by the word select bits
    function automatic logic [15:0] half_sel(input logic [31:0] v, input logic [1:0] sel,
                                             input logic [15:0] dflt);
        half_sel = (sel == fid_pkg::SEL_LOW) ? v[15:0] :
                   (sel == fid_pkg::SEL_HIGH) ? v[31:16] : dflt;
    endfunction

    // --------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------
    logic       cs_s1_reg, cs_s2_reg;
    logic       ck_s1_reg, ck_s2_reg, ck_d_reg;
    logic [7:0] dq_s1_reg, dq_s2_reg;

    // Link pins are asynchronous; only the second flop, and ck_d_reg behind it, is looked at
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            ck_s1_reg <= 1'b0;
            ck_s2_reg <= 1'b0;
            ck_d_reg  <= 1'b0;
            dq_s1_reg <= 8'h00;
            dq_s2_reg <= 8'h00;
        end else begin
            cs_s1_reg <= link.cs_n;
            cs_s2_reg <= cs_s1_reg;
            ck_s1_reg <= link.ck;
            ck_s2_reg <= ck_s1_reg;
            ck_d_reg  <= ck_s2_reg;
            dq_s1_reg <= link.dq;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    logic link_edge;
    assign link_edge = (ck_s2_reg != ck_d_reg) && !cs_s2_reg;  // Both edges carry data

    // --------------------------------------------------------
    // Frame receiver and read driver
    // --------------------------------------------------------
    fid_pkg::fid_mode_t mode_reg, mode_next;
    logic        armed_reg, armed_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [47:0] ca_reg, ca_next;
    logic [15:0] rword_reg, rword_next;
    logic [7:0]  dq_out_reg, dq_out_next;
    logic        drv_reg, drv_next;
    logic [44:0] maddr_reg, maddr_next;
    logic        mrd_reg, mrd_next;
    logic        wr_commit;
    logic        is_wr, is_rd;
    logic [15:0] rd_word;

    assign is_rd = (ca_reg[fid_pkg::CA_RD_BIT:fid_pkg::CA_LIN_BIT] == fid_pkg::CA_RD_MEM);
    assign is_wr = (ca_reg[fid_pkg::CA_RD_BIT:fid_pkg::CA_LIN_BIT] == fid_pkg::CA_WR_MEM);

    // Read source: overlay values first, memory otherwise
    always_comb begin
        rd_word = i_mem_data;
        if (mode_reg == fid_pkg::FID_MODE_ICRC) begin
            rd_word = half_sel(i_icrc_value, ca_reg[1:0], i_mem_data);
        end else if (mode_reg == fid_pkg::FID_MODE_DICRC && armed_reg) begin
            rd_word = half_sel(i_dic_result, ca_reg[1:0], i_mem_data);
        end
    end

    always_comb begin
        cnt_next    = cnt_reg;
        ca_next     = ca_reg;
        rword_next  = rword_reg;
        dq_out_next = dq_out_reg;
        drv_next    = drv_reg;
        maddr_next  = maddr_reg;
        mrd_next    = 1'b0;
        wr_commit   = 1'b0;
        if (cs_s2_reg) begin
            cnt_next = 4'h0;
            drv_next = 1'b0;
        end else if (link_edge) begin
            cnt_next = (cnt_reg == 4'hf) ? cnt_reg : 4'(cnt_reg + 4'h1);
            if (cnt_reg < fid_pkg::CA_EDGES) begin
                ca_next = {ca_reg[39:0], dq_s2_reg};
                // Fetch memory early so the word is ready before the data slots
                if (cnt_next == fid_pkg::CA_EDGES) begin
                    maddr_next = ca_next[44:0];
                    mrd_next   = (ca_next[47:45] == fid_pkg::CA_RD_MEM);
                end
            end else if (is_wr && cnt_next == fid_pkg::WR_EDGES) begin
                wr_commit = 1'b1;
            end else if (is_rd && cnt_next == fid_pkg::RD_HI_EDGE) begin
                rword_next  = rd_word;
                dq_out_next = rd_word[15:8];
                drv_next    = 1'b1;
            end else if (is_rd && cnt_next == fid_pkg::RD_LO_EDGE) begin
                dq_out_next = rword_reg[7:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg    <= 4'h0;
            ca_reg     <= 48'h0000_0000_0000;
            rword_reg  <= 16'h0000;
            dq_out_reg <= 8'h00;
            drv_reg    <= 1'b0;
            maddr_reg  <= 45'h0000_0000_0000;
            mrd_reg    <= 1'b0;
        end else begin
            cnt_reg    <= cnt_next;
            ca_reg     <= ca_next;
            rword_reg  <= rword_next;
            dq_out_reg <= dq_out_next;
            drv_reg    <= drv_next;
            maddr_reg  <= maddr_next;
            mrd_reg    <= mrd_next;
        end
    end

    // --------------------------------------------------------
    // Command decoder
    // --------------------------------------------------------
    fid_unl_t    unl_reg, unl_next;
    logic        susp_reg, susp_next;
    // Sector field spans top_address_bit down to lowest_sector_bit: ten bits
    logic [9:0]  sta_reg, sta_next;
    logic [9:0]  end_reg, end_next;
    logic        ecc_reg, ecc_next;
    logic        res_reg, res_next;
    logic [7:0]  cmd;
    logic [11:0] lo_addr;
    logic        in_dic;

    assign cmd     = dq_s2_reg;  // Command byte is the low data byte
    assign lo_addr = ca_reg[11:0];
    assign in_dic  = (mode_reg == fid_pkg::FID_MODE_DICRC);

    always_comb begin
        unl_next   = unl_reg;
        mode_next  = mode_reg;
        armed_next = armed_reg;
        susp_next  = susp_reg;
        sta_next   = sta_reg;
        end_next   = end_reg;
        ecc_next   = 1'b0;
        res_next   = 1'b0;
        if (wr_commit) begin
            armed_next = 1'b0;  // Only the write right before the read arms it
            unique case (unl_reg)
                UNL_IDLE: begin
                    if (lo_addr == fid_pkg::UNL_ADDR_A && cmd == fid_pkg::UNL_DATA_A) begin
                        unl_next = UNL_ONE;
                    end else begin
                        unique case (cmd)
                            fid_pkg::CMD_ECC_CLR: ecc_next = 1'b1;
                            fid_pkg::CMD_EXIT: mode_next = fid_pkg::FID_MODE_NORMAL;
                            fid_pkg::CMD_LD_STA: if (in_dic) begin
                                sta_next = ca_reg[fid_pkg::TOP_ADDR_BIT:fid_pkg::LOW_SECT_BIT];
                            end
                            fid_pkg::CMD_LD_END: if (in_dic) begin
                                end_next = ca_reg[fid_pkg::TOP_ADDR_BIT:fid_pkg::LOW_SECT_BIT];
                            end
                            fid_pkg::CMD_SUSP: susp_next = 1'b1;
                            fid_pkg::CMD_RESUME: begin
                                res_next  = susp_reg;
                                susp_next = 1'b0;
                            end
                            fid_pkg::CMD_RESULT: armed_next = in_dic;
                            default: ;
                        endcase
                    end
                end
                UNL_ONE: begin
                    unl_next = (lo_addr == fid_pkg::UNL_ADDR_B && cmd == fid_pkg::UNL_DATA_B)
                               ? UNL_TWO : UNL_IDLE;
                end
                UNL_TWO: begin
                    unl_next = UNL_IDLE;
                    if (lo_addr == fid_pkg::UNL_ADDR_A) begin
                        if (cmd == fid_pkg::CMD_ICRC) mode_next = fid_pkg::FID_MODE_ICRC;
                        if (cmd == fid_pkg::CMD_DICRC) mode_next = fid_pkg::FID_MODE_DICRC;
                        if (cmd == fid_pkg::CMD_BOOT) mode_next = fid_pkg::FID_MODE_BOOT;
                    end
                end
                default: unl_next = UNL_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unl_reg   <= UNL_IDLE;
            mode_reg  <= fid_pkg::FID_MODE_NORMAL;
            armed_reg <= 1'b0;
            susp_reg  <= 1'b0;
            sta_reg   <= 10'h000;
            end_reg   <= 10'h000;
            ecc_reg   <= 1'b0;
            res_reg   <= 1'b0;
        end else begin
            unl_reg   <= unl_next;
            mode_reg  <= mode_next;
            armed_reg <= armed_next;
            susp_reg  <= susp_next;
            sta_reg   <= sta_next;
            end_reg   <= end_next;
            ecc_reg   <= ecc_next;
            res_reg   <= res_next;
        end
    end

    // Outputs straight from flops
    assign o_mem_addr       = maddr_reg;
    assign o_mem_rd         = mrd_reg;
    assign o_mode           = mode_reg;
    assign o_ecc_clear      = ecc_reg;
    assign o_calc_suspended = susp_reg;
    assign o_calc_resume    = res_reg;
    assign o_start_sector   = sta_reg;
    assign o_end_sector     = end_reg;
    assign link.d_dq_o      = dq_out_reg;
    assign link.d_dq_oe_n   = ~drv_reg;  // Low while the device drives

endmodule

// >>> hdl/fid_host.sv
// Host end: turns single user requests into link frames and collects reads.
// Assumes the device answers reads within the fixed latency of the frame.
`timescale 1ns/1ns
module fid_host (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_req,
    input  wire logic        i_req_read,
    input  wire logic [44:0] i_req_addr,
    input  wire logic [15:0] i_req_wdata,
    output logic             o_ready,
    output logic [15:0]      o_rdata,
    output logic             o_rdata_valid,
    fid_link_if.host         link
);

    typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} fid_hstate_t;

    fid_hstate_t st_reg, st_next;
    logic [2:0]  ph_reg, ph_next;
    logic [3:0]  edge_reg, edge_next;
    logic [63:0] sh_reg, sh_next;
    logic        rd_reg, rd_next;
    logic        ck_reg, ck_next;
    logic        cs_n_reg, cs_n_next;
    logic [7:0]  dq_reg, dq_next;
    logic        oe_n_reg, oe_n_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        rvalid_reg, rvalid_next;
    logic [7:0]  dq_s1_reg, dq_s2_reg;

    assign o_ready        = (st_reg == H_IDLE);
    assign o_rdata        = rdata_reg;
    assign o_rdata_valid  = rvalid_reg;
    assign link.cs_n      = cs_n_reg;
    assign link.ck        = ck_reg;
    assign link.h_dq_o    = dq_reg;
    assign link.h_dq_oe_n = oe_n_reg;

    // --------------------------------------------------------
    // Frame sequencer
    // --------------------------------------------------------
    // Each slot: new byte at phase 0, clock toggle at mid-slot so data settles first
    always_comb begin
        st_next     = st_reg;
        ph_next     = ph_reg;
        edge_next   = edge_reg;
        sh_next     = sh_reg;
        rd_next     = rd_reg;
        ck_next     = ck_reg;
        cs_n_next   = cs_n_reg;
        dq_next     = dq_reg;
        oe_n_next   = oe_n_reg;
        rdata_next  = rdata_reg;
        rvalid_next = 1'b0;
        unique case (st_reg)
            H_IDLE: begin
                if (i_req) begin
                    sh_next   = {(i_req_read ? fid_pkg::CA_RD_MEM : fid_pkg::CA_WR_MEM),
                                 i_req_addr, i_req_wdata};
                    rd_next   = i_req_read;
                    edge_next = 4'h0;
                    ph_next   = 3'h0;
                    cs_n_next = 1'b0;
                    st_next   = H_RUN;
                end
            end
            H_RUN: begin
                ph_next = (ph_reg == 3'(fid_pkg::HALF_CYC - 1)) ? 3'h0 : 3'(ph_reg + 3'h1);
                if (ph_reg == 3'h0) begin
                    dq_next   = sh_reg[63:56];
                    sh_next   = {sh_reg[55:0], 8'h00};
                    // Release the bus for the device once the address is out
                    oe_n_next = rd_reg && (edge_reg >= fid_pkg::CA_EDGES);
                end
                if (ph_reg == 3'(fid_pkg::TOGGLE_PH)) begin
                    ck_next   = ~ck_reg;
                    edge_next = 4'(edge_reg + 4'h1);
                    if (rd_reg && edge_next == fid_pkg::HS_HI_EDGE) begin
                        rdata_next[15:8] = dq_s2_reg;
                    end
                    if (rd_reg && edge_next == fid_pkg::HS_LO_EDGE) begin
                        rdata_next[7:0] = dq_s2_reg;
                        rvalid_next     = 1'b1;
                    end
                end
                if (ph_reg == 3'(fid_pkg::HALF_CYC - 1) &&
                    edge_reg == (rd_reg ? fid_pkg::RD_EDGES : fid_pkg::WR_EDGES)) begin
                    cs_n_next = 1'b1;
                    oe_n_next = 1'b1;
                    ph_next   = 3'h0;
                    st_next   = H_GAP;
                end
            end
            H_GAP: begin
                ph_next = 3'(ph_reg + 3'h1);
                if (ph_reg == 3'(fid_pkg::GAP_CYC - 1)) begin
                    st_next = H_IDLE;
                end
            end
            default: st_next = H_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg     <= H_IDLE;
            ph_reg     <= 3'h0;
            edge_reg   <= 4'h0;
            sh_reg     <= 64'h0000_0000_0000_0000;
            rd_reg     <= 1'b0;
            ck_reg     <= 1'b0;
            cs_n_reg   <= 1'b1;
            dq_reg     <= 8'h00;
            oe_n_reg   <= 1'b1;
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
            dq_s1_reg  <= 8'h00;
            dq_s2_reg  <= 8'h00;
        end else begin
            st_reg     <= st_next;
            ph_reg     <= ph_next;
            edge_reg   <= edge_next;
            sh_reg     <= sh_next;
            rd_reg     <= rd_next;
            ck_reg     <= ck_next;
            cs_n_reg   <= cs_n_next;
            dq_reg     <= dq_next;
            oe_n_reg   <= oe_n_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            dq_s1_reg  <= link.dq;    // Data pins come from outside: two flops
            dq_s2_reg  <= dq_s1_reg;
        end
    end

endmodule

// >>> include/fid_link_if.sv
// Link between host controller and device: select, clock and octal data.
// Assumes one end drives data at a time; undriven data reads as all ones.
`timescale 1ns/1ns
interface fid_link_if;
    logic       cs_n;
    logic       ck;
    logic [7:0] h_dq_o;
    logic       h_dq_oe_n;
    logic [7:0] d_dq_o;
    logic       d_dq_oe_n;
    logic [7:0] dq;

    // Resolve the shared data wire; pull-up when nobody drives
    assign dq = !h_dq_oe_n ? h_dq_o : (!d_dq_oe_n ? d_dq_o : 8'hff);

    modport host (output cs_n, output ck, output h_dq_o, output h_dq_oe_n, input dq);
    modport dev  (input cs_n, input ck, input dq, output d_dq_o, output d_dq_oe_n);
endinterface

// >>> include/fid_pkg.sv
// Shared constants and types for the integrity command decoder link.
// Assumes both ends run from a 50 MHz system clock; the host makes the link clock.
package fid_pkg;

    // ------------------------------------------------------------
    // Command-address layout
    // ------------------------------------------------------------
    localparam int CA_W         = 48;
    localparam int ADDR_W       = 45;
    localparam int CA_RD_BIT    = 47;  // 1 = read, 0 = write
    localparam int CA_SPACE_BIT = 46;  // 1 = register space
    localparam int CA_LIN_BIT   = 45;  // 1 = linear burst
    localparam logic [2:0] CA_WR_MEM = 3'h1;
    localparam logic [2:0] CA_RD_MEM = 3'h5;
    localparam int TOP_ADDR_BIT = 26;  // top_address_bit
    localparam int LOW_SECT_BIT = 17;  // lowest_sector_bit
    localparam int SECT_W       = TOP_ADDR_BIT - LOW_SECT_BIT + 1;

    // ------------------------------------------------------------
    // Command codes and unlock addresses
    // ------------------------------------------------------------
    localparam logic [11:0] UNL_ADDR_A = 12'h555;
    localparam logic [11:0] UNL_ADDR_B = 12'h2aa;
    localparam logic [7:0] UNL_DATA_A  = 8'haa;
    localparam logic [7:0] UNL_DATA_B  = 8'h55;
    localparam logic [7:0] CMD_ICRC    = 8'h76;
    localparam logic [7:0] CMD_DICRC   = 8'h78;
    localparam logic [7:0] CMD_BOOT    = 8'h14;
    localparam logic [7:0] CMD_ECC_CLR = 8'h50;
    localparam logic [7:0] CMD_EXIT    = 8'hf0;
    localparam logic [7:0] CMD_LD_STA  = 8'hc3;
    localparam logic [7:0] CMD_LD_END  = 8'h3c;
    localparam logic [7:0] CMD_SUSP    = 8'hc0;
    localparam logic [7:0] CMD_RESUME  = 8'hc1;
    localparam logic [7:0] CMD_RESULT  = 8'h60;
    localparam logic [1:0] SEL_LOW     = 2'h0;
    localparam logic [1:0] SEL_HIGH    = 2'h1;

    // ------------------------------------------------------------
    // Link timing and frame shape
    // ------------------------------------------------------------
    localparam int SYS_CLK_NS   = 20;
    localparam int LINK_HALF_NS = 80;
    localparam int GAP_NS       = 80;
    localparam int HALF_CYC     = (LINK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int TOGGLE_PH    = HALF_CYC / 2;
    localparam int GAP_CYC      = (GAP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [3:0] CA_EDGES   = 4'h6;
    localparam logic [3:0] WR_EDGES   = 4'h8;
    localparam logic [3:0] RD_EDGES   = 4'hc;
    localparam logic [3:0] RD_HI_EDGE = 4'h7;
    localparam logic [3:0] RD_LO_EDGE = 4'h9;
    localparam logic [3:0] HS_HI_EDGE = 4'h9;
    localparam logic [3:0] HS_LO_EDGE = 4'hb;

    typedef enum logic [1:0] {
        FID_MODE_NORMAL,
        FID_MODE_ICRC,
        FID_MODE_DICRC,
        FID_MODE_BOOT
    } fid_mode_t;

endpackage
